// File: design/msdce_exec.sv
// Purpose: executes block-mode reads/writes, block-size setup and DMA reads
// Assumes: host sends/takes data only while DRQ (or DMARQ) stands
// Notes:   CHS addresses are handled as a packed linear value
// Function
// - extended block read runs like block read, only in LBA mode.
// - block write sets BSY at once, before any data handshake.
// - block writes interrupt once per block, not per sector.
// - DRQ stands through each block and qualifies every data beat.
// - leftover sectors move as one final partial block.
// - block write while block mode disabled aborts.
// - write error stops at failing sector; no further blocks.
// - extended block write takes 48-bit address, 16-bit count, LBA only.
// - block size comes from count register; 1, 2, 4, 8, 16 allowed.
// - block-size command sets BSY then checks the count.
// - valid block size is stored and block mode enabled.
// - invalid block size aborts and disables block mode.
// - count of zero disables block mode.
// - soft reset keeps mode after 66h, reverts to sixteen after CCh.
// - device starts DMA movement with DMARQ; host channel moves data.
// - DMA read raises exactly one interrupt, at completion.
// - during DMA transfer BSY or DRQ stays set.
// - DMA success leaves last transferred sector in address registers.
// - DMA unrecoverable error ends command at failing sector address.
// - block reads continue only after correctable errors, else end after block.
// - block read posts error as the failing sector's status arrives yet still transfers data.
`timescale 1ns/1ns

// two-entry skid buffer; all outputs from flops
module msdce_fifo2 #(
    parameter int W = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic         clear,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    logic [W-1:0] skidData;
    logic         inFire;

    assign inFire = inValid && inReady;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            outValid <= 1'b0;
            inReady  <= 1'b1;
            outData  <= '0;
            skidData <= '0;
        end
        else if (clear)
        begin
            outValid <= 1'b0;
            inReady  <= 1'b1;
        end
        else if (!outValid || outReady)
        begin
            if (!inReady)
            begin
                outData  <= skidData;
                outValid <= 1'b1;
                inReady  <= 1'b1;
            end
            else
            begin
                outValid <= inFire;
                if (inFire)
                    outData <= inData;
            end
        end
        else if (inFire)
        begin
            skidData <= inData;
            inReady  <= 1'b0;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////

module msdce_exec #(
    parameter int DW = 16
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    // command and parameters
    input  wire logic                  cmdValid,
    input  wire logic [7:0]            cmdCode,
    input  wire logic [15:0]           countIn,
    input  wire logic [47:0]           lbaIn,
    input  wire logic                  lbaMode,
    input  wire logic                  softReset,
    input  wire logic                  featureValid,
    input  wire logic [7:0]            featureCode,
    // register readback and status
    input  wire logic                  hob,
    input  wire logic [1:0]            readSel,
    output logic [7:0]                 readData,
    input  wire logic                  statusRead,
    output msdce_pkg::msdce_status_t   taskStatus,
    output logic                       multEnabled,
    output logic [4:0]                 multSize,
    // host data
    input  wire logic [DW-1:0]         hostWrData,
    input  wire logic                  hostWrValid,
    output logic                       hostWrReady,
    output logic [DW-1:0]              hostRdData,
    output logic                       hostRdValid,
    input  wire logic                  hostRdReady,
    output logic                       dmarq,
    // media
    output logic                       mediaReq,
    output logic                       mediaWrite,
    output logic [47:0]                mediaLba,
    output logic [16:0]                mediaCount,
    output logic [DW-1:0]              mediaWrData,
    output logic                       mediaWrValid,
    input  wire logic                  mediaWrReady,
    input  wire logic [DW-1:0]         mediaRdData,
    input  wire logic                  mediaRdValid,
    output logic                       mediaRdReady,
    input  wire logic                  mediaStatValid,
    input  wire msdce_pkg::msdce_mstat_t mediaStat
);
    msdce_pkg::msdce_state_t state;
    logic        cmdWrite, cmdDma, cmdExt, cmdSet, keepMode, stopAfter, drqShown;
    logic [15:0] cmdCount;
    logic [16:0] remain, hostCnt, medCnt, blkSize;
    logic [47:0] curLba, addrReg;
    logic        cmdAccept, known, sizeOk, hostWrFire, hostRdFire, hardErr;

    assign known = cmdCode == msdce_pkg::CMD_RD_MULT || cmdCode == msdce_pkg::CMD_RD_MULT_EXT
                || cmdCode == msdce_pkg::CMD_WR_MULT || cmdCode == msdce_pkg::CMD_WR_MULT_EXT
                || cmdCode == msdce_pkg::CMD_SET_MULT || cmdCode == msdce_pkg::CMD_RD_DMA
                || cmdCode == msdce_pkg::CMD_RD_DMA_NR;
    assign cmdAccept = cmdValid && known && state == msdce_pkg::ST_IDLE && !softReset;
    assign sizeOk = cmdCount[7:0] == 8'h01 || cmdCount[7:0] == 8'h02 || cmdCount[7:0] == 8'h04
                 || cmdCount[7:0] == 8'h08 || cmdCount[7:0] == 8'h10;
    // partial final block is whatever remains
    assign blkSize = (cmdDma || remain < {12'h000, multSize}) ? remain
                   : {12'h000, multSize};
    assign hostWrFire = hostWrValid && hostWrReady && taskStatus.drq && cmdWrite;
    assign hostRdFire = hostRdValid && hostRdReady && (taskStatus.drq || dmarq);
    assign hardErr = mediaStatValid && mediaStat.err && !mediaStat.corr;

    ////////////////////////////////////////////////////////////////////////////
    // data buffers

    msdce_fifo2 #(.W(DW)) wrBuf (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .clear    (state == msdce_pkg::ST_DONE),
        .inValid  (hostWrValid && taskStatus.drq && cmdWrite),
        .inReady  (hostWrReady),
        .inData   (hostWrData),
        .outValid (mediaWrValid),
        .outReady (mediaWrReady),
        .outData  (mediaWrData)
    );

    msdce_fifo2 #(.W(DW)) rdBuf (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .clear    (state == msdce_pkg::ST_DONE),
        .inValid  (mediaRdValid),
        .inReady  (mediaRdReady),
        .inData   (mediaRdData),
        .outValid (hostRdValid),
        .outReady (hostRdReady && (taskStatus.drq || dmarq)),
        .outData  (hostRdData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // command sequencing

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state     <= msdce_pkg::ST_IDLE;
            cmdWrite  <= 1'b0;
            cmdDma    <= 1'b0;
            cmdExt    <= 1'b0;
            cmdSet    <= 1'b0;
            cmdCount  <= 16'h0000;
            remain    <= 17'h00000;
            hostCnt   <= 17'h00000;
            medCnt    <= 17'h00000;
            curLba    <= 48'h000000000000;
            stopAfter <= 1'b0;
        end
        else if (softReset)
            state <= msdce_pkg::ST_IDLE;
        else
        begin
            case (state)
                msdce_pkg::ST_IDLE:
                begin
                    if (cmdAccept)
                    begin
                        state    <= msdce_pkg::ST_CHECK;
                        cmdWrite <= cmdCode == msdce_pkg::CMD_WR_MULT
                                 || cmdCode == msdce_pkg::CMD_WR_MULT_EXT;
                        cmdDma   <= cmdCode == msdce_pkg::CMD_RD_DMA
                                 || cmdCode == msdce_pkg::CMD_RD_DMA_NR;
                        cmdExt   <= cmdCode == msdce_pkg::CMD_RD_MULT_EXT
                                 || cmdCode == msdce_pkg::CMD_WR_MULT_EXT;
                        cmdSet   <= cmdCode == msdce_pkg::CMD_SET_MULT;
                        cmdCount <= countIn;
                        curLba   <= lbaIn;
                        stopAfter <= 1'b0;
                    end
                end
                msdce_pkg::ST_CHECK:
                begin
                    // legacy count uses the low byte only; zero is the maximum
                    if (cmdExt)
                        remain <= cmdCount == 16'h0000 ? msdce_pkg::EXT_ZERO
                                : {1'b0, cmdCount};
                    else
                        remain <= cmdCount[7:0] == 8'h00 ? msdce_pkg::LEGACY_ZERO
                                : {9'h000, cmdCount[7:0]};
                    if (cmdSet || (!cmdDma && !multEnabled) || (cmdExt && !lbaMode))
                        state <= msdce_pkg::ST_DONE;
                    else
                        state <= msdce_pkg::ST_BLOCK;
                end
                msdce_pkg::ST_BLOCK:
                begin
                    hostCnt <= blkSize;
                    medCnt  <= blkSize;
                    state   <= msdce_pkg::ST_XFER;
                end
                msdce_pkg::ST_XFER:
                begin
                    if (hostWrFire || hostRdFire)
                        hostCnt <= hostCnt - 17'h00001;
                    if (mediaStatValid)
                    begin
                        if (mediaStat.err && !mediaStat.corr && (cmdWrite || cmdDma))
                            state <= msdce_pkg::ST_DONE;
                        else
                        begin
                            medCnt <= medCnt - 17'h00001;
                            remain <= remain - 17'h00001;
                            curLba <= curLba + 48'h000000000001;
                        end
                        if (hardErr)
                            stopAfter <= 1'b1;
                    end
                    if (hostCnt == 17'h00000 && medCnt == 17'h00000)
                        state <= (remain == 17'h00000 || stopAfter) ? msdce_pkg::ST_DONE
                               : msdce_pkg::ST_BLOCK;
                end
                msdce_pkg::ST_DONE:
                    state <= msdce_pkg::ST_IDLE;
                default:
                    state <= msdce_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // media requests, one per block (whole command for dma)

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mediaReq   <= 1'b0;
            mediaWrite <= 1'b0;
            mediaLba   <= 48'h000000000000;
            mediaCount <= 17'h00000;
        end
        else
        begin
            mediaReq <= state == msdce_pkg::ST_BLOCK && !softReset;
            if (state == msdce_pkg::ST_BLOCK)
            begin
                mediaWrite <= cmdWrite;
                mediaLba   <= curLba;
                mediaCount <= blkSize;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // block size mode

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            multSize    <= msdce_pkg::MULT_DEFAULT;
            multEnabled <= msdce_pkg::MULT_EN_DEFAULT;
            keepMode    <= msdce_pkg::KEEP_DEFAULT;
        end
        else
        begin
            if (featureValid && featureCode == msdce_pkg::FEAT_KEEP_MODE)
                keepMode <= 1'b1;
            else if (featureValid && featureCode == msdce_pkg::FEAT_REVERT_MODE)
                keepMode <= 1'b0;
            if (softReset)
            begin
                if (!keepMode)
                begin
                    multSize    <= msdce_pkg::MULT_DEFAULT;
                    multEnabled <= 1'b1;
                end
            end
            else if (state == msdce_pkg::ST_CHECK && cmdSet)
            begin
                multEnabled <= sizeOk;
                if (sizeOk)
                    multSize <= cmdCount[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // task status

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            taskStatus <= '0;
            dmarq      <= 1'b0;
            drqShown   <= 1'b0;
        end
        else if (softReset)
        begin
            taskStatus <= '0;
            dmarq      <= 1'b0;
        end
        else
        begin
            dmarq <= cmdDma && state == msdce_pkg::ST_XFER && hostCnt != 17'h00000;
            if (statusRead)
                taskStatus.intrq <= 1'b0;
            if (cmdAccept)
            begin
                taskStatus.bsy  <= 1'b1;
                taskStatus.err  <= 1'b0;
                taskStatus.abrt <= 1'b0;
            end
            if (state == msdce_pkg::ST_CHECK && !cmdDma
                && (cmdSet ? (!sizeOk && cmdCount[7:0] != 8'h00)
                           : (!multEnabled || (cmdExt && !lbaMode))))
            begin
                taskStatus.abrt <= 1'b1;
                taskStatus.err  <= 1'b1;
            end
            if (state == msdce_pkg::ST_BLOCK)
            begin
                drqShown <= 1'b0;
                if (cmdWrite)
                begin
                    taskStatus.drq <= 1'b1;
                    taskStatus.bsy <= 1'b0;
                end
            end
            if (state == msdce_pkg::ST_XFER)
            begin
                if (!cmdWrite && !cmdDma && !drqShown && hostRdValid)
                begin
                    drqShown         <= 1'b1;
                    taskStatus.drq   <= 1'b1;
                    taskStatus.bsy   <= 1'b0;
                    taskStatus.intrq <= 1'b1;
                end
                if ((hostWrFire || hostRdFire) && hostCnt == 17'h00001)
                begin
                    taskStatus.drq <= 1'b0;
                    taskStatus.bsy <= 1'b1;
                end
                if (mediaStatValid && mediaStat.err)
                    taskStatus.err <= 1'b1;
                if (cmdWrite && hostCnt == 17'h00000 && medCnt == 17'h00000)
                    taskStatus.intrq <= 1'b1;
            end
            if (state == msdce_pkg::ST_DONE)
            begin
                taskStatus.bsy <= 1'b0;
                taskStatus.drq <= 1'b0;
                if (cmdDma || cmdSet || taskStatus.err)
                    taskStatus.intrq <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address registers and readback

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addrReg  <= 48'h000000000000;
            readData <= 8'h00;
        end
        else
        begin
            if (cmdAccept)
                addrReg <= lbaIn;
            else if (state == msdce_pkg::ST_DONE && !cmdSet)
                addrReg <= ((cmdDma || cmdWrite) && stopAfter) ? curLba
                         : curLba - 48'h000000000001;
            case (readSel)
                msdce_pkg::SEL_COUNT: readData <= hob ? remain[15:8] : remain[7:0];
                msdce_pkg::SEL_LOW:   readData <= hob ? addrReg[31:24] : addrReg[7:0];
                msdce_pkg::SEL_MID:   readData <= hob ? addrReg[39:32] : addrReg[15:8];
                msdce_pkg::SEL_HIGH:  readData <= hob ? addrReg[47:40] : addrReg[23:16];
                default:              readData <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    bsy_on_cmd_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmdAccept |=> taskStatus.bsy && !taskStatus.drq)
        else $error("busy not set on command");
    mult_reject_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state == msdce_pkg::ST_CHECK && cmdWrite && !multEnabled && !softReset
        |=> taskStatus.abrt && state == msdce_pkg::ST_DONE)
        else $error("disabled block write not aborted");
    ext_lba_only_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state == msdce_pkg::ST_CHECK && cmdExt && !lbaMode && !softReset |=> taskStatus.abrt)
        else $error("extended command ran outside lba mode");
    partial_block_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state == msdce_pkg::ST_BLOCK && !cmdDma && remain < {12'h000, multSize} && !softReset
        |=> hostCnt == $past(remain) && medCnt == $past(remain))
        else $error("partial block size wrong");
    blk_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state == msdce_pkg::ST_XFER && cmdWrite && hostCnt == 17'h00000
        && medCnt == 17'h00000 && !softReset |=> taskStatus.intrq)
        else $error("no interrupt at block end");
    dma_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmdDma && state == msdce_pkg::ST_XFER |-> taskStatus.bsy || taskStatus.drq)
        else $error("dma phase with neither busy nor drq");
    dma_one_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(taskStatus.intrq) && cmdDma |-> $past(state) == msdce_pkg::ST_DONE)
        else $error("dma interrupt before completion");
    set_mult_ok_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state == msdce_pkg::ST_CHECK && cmdSet && sizeOk && !softReset
        |=> multEnabled && multSize == $past(cmdCount[4:0]) ##1 taskStatus.intrq)
        else $error("valid block size not stored");
    set_mult_bad_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state == msdce_pkg::ST_CHECK && cmdSet && !sizeOk && !softReset |=> !multEnabled)
        else $error("bad block size left block mode on");
    wr_err_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state == msdce_pkg::ST_XFER && cmdWrite && hardErr && !softReset
        |=> state == msdce_pkg::ST_DONE ##1 addrReg == $past(curLba, 2) && !mediaReq)
        else $error("write error did not stop at failing sector");
    soft_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        softReset && !keepMode |=> multEnabled && multSize == msdce_pkg::MULT_DEFAULT)
        else $error("soft reset did not restore block size");
endmodule

// File: design/msdce_pkg.sv
// Purpose: shared constants and types of the block-mode / DMA command executor
// Assumes: one sector is carried as one data beat on the host and media streams
// Notes:   counts are 17 bits so that an extended count of zero (65536) fits
package msdce_pkg;

    // command codes
    localparam logic [7:0] CMD_RD_MULT     = 8'hc4;
    localparam logic [7:0] CMD_RD_MULT_EXT = 8'h29;
    localparam logic [7:0] CMD_WR_MULT     = 8'hc5;
    localparam logic [7:0] CMD_WR_MULT_EXT = 8'h39;
    localparam logic [7:0] CMD_SET_MULT    = 8'hc6;
    localparam logic [7:0] CMD_RD_DMA      = 8'hc8;
    localparam logic [7:0] CMD_RD_DMA_NR   = 8'hc9;

    // feature settings that steer soft reset
    localparam logic [7:0] FEAT_KEEP_MODE   = 8'h66;
    localparam logic [7:0] FEAT_REVERT_MODE = 8'hcc;

    // power-on values
    localparam logic [4:0] MULT_DEFAULT    = 5'h10;
    localparam logic       MULT_EN_DEFAULT = 1'b1;
    localparam logic       KEEP_DEFAULT    = 1'b0;

    // readback selects
    localparam logic [1:0] SEL_COUNT = 2'h0;
    localparam logic [1:0] SEL_LOW   = 2'h1;
    localparam logic [1:0] SEL_MID   = 2'h2;
    localparam logic [1:0] SEL_HIGH  = 2'h3;

    // count width and counts of zero
    localparam int          CNT_W        = 17;
    localparam logic [16:0] LEGACY_ZERO  = 17'h00100;
    localparam logic [16:0] EXT_ZERO     = 17'h10000;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_CHECK = 5'b00010,
        ST_BLOCK = 5'b00100,
        ST_XFER  = 5'b01000,
        ST_DONE  = 5'b10000
    } msdce_state_t;

    typedef struct packed {
        logic bsy;
        logic drq;
        logic err;
        logic abrt;
        logic intrq;
    } msdce_status_t;

    typedef struct packed {
        logic err;
        logic corr;
    } msdce_mstat_t;

endpackage

// File: tb/msdce_media_model.sv
// Purpose: behavioural media serving one read beat per sector
// Assumes: writes always accepted; status follows every beat
// Notes:   idle read data shows the inverse of the next word
`timescale 1ns/1ns
module msdce_media_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // block request and beats
    input  wire logic        mediaReq,
    input  wire logic        mediaWrite,
    input  wire logic [16:0] mediaCount,
    input  wire logic        mediaWrValid,
    input  wire logic        mediaRdReady,
    output logic [15:0]      mediaRdData,
    output logic             mediaRdValid,
    output logic             mediaStatValid
);
    logic [16:0] left;
    logic        isWrite;
    logic [15:0] word;
    assign mediaRdValid = (left != 17'h00000) && !isWrite;
    assign mediaRdData = mediaRdValid ? word : ~word;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            left <= 17'h00000;
            isWrite <= 1'b0;
            word <= 16'h0000;
            mediaStatValid <= 1'b0;
        end
        else
        begin
            mediaStatValid <= (mediaRdValid && mediaRdReady) || mediaWrValid;
            if (mediaReq)
                left <= mediaCount;
            if (mediaReq)
                isWrite <= mediaWrite;
            else if (mediaRdValid && mediaRdReady)
                left <= left - 17'h00001;
            if (mediaRdValid && mediaRdReady)
                word <= word + 16'h1357;
        end
    end
endmodule

// File: tb/tb_multi_sector_dma_cmd_exec.sv
// Purpose: bench for the block-mode and dma command executor
// Assumes: every command except block read ends with an interrupt; block reads raise one per block
// Notes:   queued notes hold {abort, enabled, size}
`timescale 1ns/1ns
module tb_multi_sector_dma_cmd_exec;
    logic        clk_sys = 1'b0, rst_b = 1'b0, cmdValid = 1'b0, lbaMode = 1'b1;
    logic        softReset = 1'b0, featureValid = 1'b0, statusRead = 1'b0, hostRdReady = 1'b1;
    logic        prevIrq = 1'b0, multEnabled, dmarq, mediaReq, mediaWrite, mediaWrValid;
    logic        mediaRdValid, mediaRdReady, mediaStatValid;
    logic        hob = 1'b0, hostRdValid;
    logic [15:0] hostRdData, expWord = 16'h0000;
    logic [7:0]  cmdCode = 8'h00, featureCode = 8'h00, readData;
    logic [7:0]  codes[4] = '{8'hc4, 8'h29, 8'hc5, 8'h39};
    logic [15:0] countIn = 16'h0000, mediaRdData;
    logic [47:0] lbaIn = 48'h0;
    logic [1:0]  readSel = 2'h0;
    logic [4:0]  multSize;
    logic [16:0] mediaCount;
    logic [6:0]  q[$];
    int          n_mismatch = 0, n_compared = 0;
    msdce_pkg::msdce_status_t taskStatus;
    always #50 clk_sys = ~clk_sys;
    msdce_exec msdce_exec_i (.clk_sys, .rst_b, .cmdValid, .cmdCode, .countIn, .lbaIn, .lbaMode,
        .softReset, .featureValid, .featureCode, .hob, .readSel, .readData, .statusRead,
        .taskStatus, .multEnabled, .multSize, .hostWrData(16'h0000), .hostWrValid(1'b0),
        .hostWrReady(), .hostRdData, .hostRdValid, .hostRdReady, .dmarq, .mediaReq,
        .mediaWrite, .mediaLba(), .mediaCount, .mediaWrData(), .mediaWrValid,
        .mediaWrReady(1'b1), .mediaRdData, .mediaRdValid, .mediaRdReady, .mediaStatValid,
        .mediaStat(2'h0));
    msdce_media_model msdce_media_model_i (.clk_sys, .rst_b, .mediaReq, .mediaWrite,
        .mediaCount, .mediaWrValid, .mediaRdReady, .mediaRdData, .mediaRdValid, .mediaStatValid);
    task automatic check(string nm, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic issue(logic [7:0] code, logic [15:0] cnt, logic [6:0] note);
        // wait out a running command, acknowledging its block interrupts
        while ((taskStatus.bsy | taskStatus.drq) !== 1'b0)
        begin
            statusRead = taskStatus.intrq;
            @(negedge clk_sys);
        end
        statusRead = 1'b0;
        q.push_back(note);
        cmdCode = code;
        countIn = cnt;
        cmdValid = 1'b1;
        @(negedge clk_sys) cmdValid = 1'b0;
        check("bsy", 16'h1, 16'(taskStatus.bsy));
        for (int k = 0; k < 400 && taskStatus.intrq !== 1'b1; k++)
            @(negedge clk_sys);
        check("irq", 16'h1, 16'(taskStatus.intrq));
        statusRead = 1'b1;
        @(negedge clk_sys) statusRead = 1'b0;
        @(negedge clk_sys);
    endtask
    // random host stalls; result notes compared as interrupts rise
    always @(negedge clk_sys)
    begin
        hostRdReady = 1'($urandom);
        if ((hostRdValid & hostRdReady & (taskStatus.drq | dmarq)) === 1'b1)
        begin
            check("read data", expWord, hostRdData);
            expWord += 16'h1357;
        end
        if (dmarq === 1'b1)
            check("bsy or drq", 16'h1, 16'(taskStatus.bsy | taskStatus.drq));
        if (taskStatus.intrq === 1'b1 && !prevIrq && q.size() > 0)
        begin
            check("abort", 16'(q[0][6]), 16'(taskStatus.abrt));
            check("enable", 16'(q[0][5]), 16'(multEnabled));
            if (q[0][5])
                check("size", 16'(q[0][4:0]), 16'(multSize));
            void'(q.pop_front());
        end
        prevIrq = taskStatus.intrq === 1'b1;
    end
    initial
    begin
        void'($urandom(32'hf336));
        repeat (20) @(negedge clk_sys);
        rst_b = 1'b1;
        @(negedge clk_sys);
        for (int i = 0; i < 5; i++)
            issue(8'hc6, 16'(1 << i), {2'b01, 5'(1 << i)});
        $display("block sizes done");
        issue(8'hc6, 16'h0003 + 16'($urandom % 2) * 16'h2, 7'h40);
        foreach (codes[i])
            issue(codes[i], 16'h0004, 7'h40);
        issue(8'hc6, 16'h0000, 7'h00);
        $display("refusals done");
        softReset = 1'b1;
        @(negedge clk_sys) softReset = 1'b0;
        @(negedge clk_sys) check("revert", 16'h30, 16'({multEnabled, multSize}));
        lbaMode = 1'b0;
        issue(8'h29, 16'h0002, 7'h70);
        issue(8'h39, 16'h0002, 7'h70);
        lbaMode = 1'b1;
        featureCode = 8'h66;
        featureValid = 1'b1;
        @(negedge clk_sys) featureValid = 1'b0;
        issue(8'hc6, 16'h0002, 7'h22);
        softReset = 1'b1;
        @(negedge clk_sys) softReset = 1'b0;
        @(negedge clk_sys) check("keep", 16'h22, 16'({multEnabled, multSize}));
        $display("soft reset done");
        // second, partial block raises its own interrupt
        q.push_back(7'h22);
        issue(8'hc4, 16'h0003, 7'h22);
        $display("block read done");
        for (int i = 0; i < 2; i++)
        begin
            lbaIn = {16'($urandom), 32'($urandom)};
            issue(8'hc8 + 8'(i), 16'h0003, 7'h22);
            readSel = 2'h1;
            hob = 1'b0;
            repeat (2) @(negedge clk_sys);
            check("last addr", {8'h00, 8'(lbaIn[7:0] + 8'h2)}, 16'(readData));
            hob = 1'b1;
            repeat (2) @(negedge clk_sys);
            check("prev addr", {8'h00, 8'((lbaIn + 48'h2) >> 24)}, 16'(readData));
        end
        $display("dma reads done");
        summarize();
    end
    initial
    begin
        #2000000;
        n_mismatch++;
        summarize();
    end
endmodule
